// ===== rtl/sdram_pin_pkg.sv
// constants for the sdram pin interface block
package sdram_pin_pkg;
  localparam logic [1:0] CMD_W      = 2'h3;
  // command codes as {row, column, write} strobe levels, active low
  localparam logic [2:0] CMD_NOP    = 3'h7;
  localparam logic [2:0] CMD_ACT    = 3'h3;
  localparam logic [2:0] CMD_READ   = 3'h5;
  localparam logic [2:0] CMD_WRITE  = 3'h4;
  localparam logic [2:0] CMD_PRE    = 3'h2;
  localparam logic [2:0] CMD_REF    = 3'h1;
  localparam logic [2:0] CMD_MRS    = 3'h0;
  localparam logic [2:0] CMD_BST    = 3'h6;
  localparam int unsigned ROW_BIT   = 2;
  localparam int unsigned COL_BIT   = 1;
  localparam int unsigned WR_BIT    = 0;
  localparam logic       PIN_IDLE   = 1'h1;
  localparam logic       MASK_ON    = 1'h1;
  localparam logic       MASK_OFF   = 1'h0;
  localparam int unsigned CMD_BITS  = 3;
  localparam logic       CLK_REST   = 1'h0;
  localparam logic       OE_OFF     = 1'h0;
  localparam logic       OE_ON      = 1'h1;
  // output enable slots, one per pin group
  localparam int unsigned OE_COUNT  = 4;
  localparam int unsigned OE_CMD    = 0;
  localparam int unsigned OE_MASK   = 1;
  localparam int unsigned OE_CLK    = 2;
  localparam int unsigned OE_ADDR   = 3;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_INIT  = 2'b01,
    ST_RUN   = 2'b10,
    ST_OFF   = 2'b11
  } pin_state_t;
endpackage

// ===== rtl/sdram_pin_interface.sv
// pin stage of the external sdram interface
// Operation
// [R1] command encoded on row, column, write strobes
// [R2] mask high until init done, then low
// [R3] precharge bit replaces address ten on sdram access
// [R4] refresh allowed during concurrent non-sdram accesses
// [R5] sdram ignores write data when mask high
// [R6] sdram floats outputs on read when mask high
// [R7] clock gate output suspends memory clock
// [R8] disable bit stops all interface switching; address ten still follows the shared bit while off
// [R9] pins floating in reset, high afterwards
`timescale 1ns/1ns
`default_nettype none
module sdram_pin_interface
  import sdram_pin_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  // control from the sdram controller
  input  wire logic       interface_disable_bit_i,
  input  wire logic       init_done_i,
  input  wire logic [2:0] cmd_i,
  input  wire logic       cmd_valid_i,
  input  wire logic       sdram_access_i,
  input  wire logic       precharge_address_bit_i,
  input  wire logic       clock_gate_i,
  input  wire logic       shared_address_bit_ten_i,
  // sdram pins
  output logic            row_strobe_out_o,
  output logic            column_strobe_out_o,
  output logic            write_strobe_out_o,
  output logic            memory_clock_gate_out_o,
  output logic            byte_mask_out_o,
  output logic            memory_clock_out_o,
  output logic            cmd_oe_o,
  output logic            mask_oe_o,
  output logic            clock_oe_o,
  // address bit ten, shared with the other external devices
  output logic            address_ten_o,
  output logic            address_ten_oe_o
);
  import sdram_pin_pkg::*;

  // controller state and registered pin values
  pin_state_t              state_q;
  pin_state_t              state_d;
  logic [CMD_BITS-1:0]     cmd_q;
  logic [CMD_BITS-1:0]     cmd_d;
  logic                    cke_q;
  logic                    cke_d;
  logic                    mask_q;
  logic                    mask_d;
  logic                    a10_q;
  logic                    a10_d;
  logic                    clk_q;
  logic                    clk_d;
  logic [OE_COUNT-1:0]     oe_q;
  logic                    oe_d;

  // decode of the current state and request
  logic                    running;
  logic                    in_run;
  logic                    off_req;
  logic                    cmd_live;
  logic                    use_a10;

  function automatic logic is_running(input pin_state_t st);
    return (st == ST_INIT) || (st == ST_RUN);
  endfunction

  function automatic logic pick_bit(
    input logic sel,
    input logic when_set,
    input logic when_clear
  );
    return sel ? when_set : when_clear;
  endfunction

  assign running  = is_running(state_q);
  assign in_run   = (state_q == ST_RUN);
  assign off_req  = interface_disable_bit_i;
  assign cmd_live = running && cmd_valid_i;
  // a refresh needs no shared address, so it may overlap other bus users
  assign use_a10  = cmd_live && sdram_access_i; // R3 R4

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (off_req) begin
          state_d = ST_OFF;
        end else begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        if (off_req) begin
          state_d = ST_OFF;
        end else if (init_done_i) begin
          state_d = ST_RUN;
        end else begin
          state_d = ST_INIT;
        end
      end
      ST_RUN: begin
        if (off_req) begin
          state_d = ST_OFF; // R8
        end else begin
          state_d = ST_RUN;
        end
      end
      ST_OFF: begin
        if (off_req) begin
          state_d = ST_OFF;
        end else begin
          state_d = ST_INIT;
        end
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  assign oe_d   = OE_ON; // R9
  assign cmd_d  = cmd_live ? cmd_i : CMD_NOP; // R1 R8
  assign cke_d  = pick_bit(running, clock_gate_i, cke_q); // R7 R8
  assign mask_d = in_run ? MASK_OFF : MASK_ON; // R2
  assign a10_d  = pick_bit(use_a10, precharge_address_bit_i, shared_address_bit_ten_i); // R3
  // memory clock frozen outside init and run, so only address ten still switches
  assign clk_d  = pick_bit(running, ~clk_q, clk_q); // R8

  // state register
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // clock gate pin
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cke_q <= PIN_IDLE;
    end else begin
      cke_q <= cke_d;
    end
  end

  // byte mask pin
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_q <= MASK_ON;
    end else begin
      mask_q <= mask_d;
    end
  end

  // address ten pin
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      a10_q <= PIN_IDLE;
    end else begin
      a10_q <= a10_d;
    end
  end

  // memory clock pin
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_q <= CLK_REST;
    end else begin
      clk_q <= clk_d;
    end
  end

  // one flop per command strobe
  for (genvar b = 0; b < CMD_BITS; b++) begin : g_strobe
    logic bit_q;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        bit_q <= CMD_NOP[b];
      end else begin
        bit_q <= cmd_d[b];
      end
    end
    assign cmd_q[b] = bit_q;
  end

  // one enable flop per pin group, off while in reset
  for (genvar e = 0; e < OE_COUNT; e++) begin : g_enable
    logic en_q;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        en_q <= OE_OFF; // R9
      end else begin
        en_q <= oe_d;
      end
    end
    assign oe_q[e] = en_q;
  end

  // pin values
  assign row_strobe_out_o        = cmd_q[ROW_BIT]; // R1
  assign column_strobe_out_o     = cmd_q[COL_BIT];
  assign write_strobe_out_o      = cmd_q[WR_BIT];
  assign memory_clock_gate_out_o = cke_q;
  assign byte_mask_out_o         = mask_q;
  assign memory_clock_out_o      = clk_q;
  assign address_ten_o           = a10_q;

  // pin enables
  assign cmd_oe_o                = oe_q[OE_CMD];
  assign mask_oe_o               = oe_q[OE_MASK];
  assign clock_oe_o              = oe_q[OE_CLK];
  assign address_ten_oe_o        = oe_q[OE_ADDR];
endmodule
`default_nettype wire

// ===== test/sdram_pin_properties.sv
// assertions on the sdram pin stage ports
`timescale 1ns/1ns
`default_nettype none
module sdram_pin_properties (input wire logic sys_clk_i, arst_n_i, interface_disable_bit_i,
  init_done_i, cmd_valid_i, sdram_access_i, precharge_address_bit_i, clock_gate_i,
  shared_address_bit_ten_i, row_strobe_out_o, column_strobe_out_o, write_strobe_out_o,
  memory_clock_gate_out_o, byte_mask_out_o, memory_clock_out_o, address_ten_o, cmd_oe_o,
  input wire logic [2:0] cmd_i);
  import sdram_pin_pkg::*;
  wire d = interface_disable_bit_i;
  wire [2:0] s = {row_strobe_out_o, column_strobe_out_o, write_strobe_out_o};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_cmd_encode: assert property ($past(arst_n_i, 2) && !$past(d, 2) && !$past(d)
    && $past(cmd_valid_i) |-> s == $past(cmd_i)) else $error("strobes wrong");
  a_mask_low: assert property ($fell(byte_mask_out_o) |->
    $past(init_done_i, 2)) else $error("mask dropped early");
  a_mask_init: assert property ($past(arst_n_i) && !$past(init_done_i) |->
    byte_mask_out_o) else $error("mask low in init");
  a_addr_select: assert property ($past(arst_n_i, 2) && !$past(d, 2) |-> address_ten_o ==
    (($past(cmd_valid_i) && $past(sdram_access_i)) ? $past(precharge_address_bit_i)
    : $past(shared_address_bit_ten_i))) else $error("address ten wrong");
  a_cke_follow: assert property ($past(arst_n_i, 2) && !$past(d, 2) && !$past(d) |->
    memory_clock_gate_out_o == $past(clock_gate_i)) else $error("clock gate wrong");
  a_off_freeze: assert property ($past(d, 2) && $past(d) |->
    $stable(memory_clock_out_o) && s == CMD_NOP) else $error("switching while off");
  a_pins_driven: assert property ($past(arst_n_i) |-> cmd_oe_o) else $error("pins float");
  cover property ($fell(byte_mask_out_o));
  cover property ($past(d) && d);
  cover property (cmd_valid_i && cmd_i == CMD_REF && !sdram_access_i);
endmodule
bind sdram_pin_interface sdram_pin_properties chk (.*);
`default_nettype wire

// ===== test/sdram_chip_model.sv
// sdram chip: takes data only while the mask is low
`timescale 1ns/1ns
`default_nettype none
module sdram_chip_model (input wire logic clk_i, mask_i, input wire logic [2:0] cmd_i,
  output logic took_o);
  import sdram_pin_pkg::*;
  // clock and pins leave the same flop edge, so look just after it
  always @(posedge clk_i) begin
    #1 took_o <= !mask_i && (cmd_i == CMD_WRITE || cmd_i == CMD_READ);
  end
endmodule
`default_nettype wire

// ===== test/sdram_pin_interface_bench.sv
// self-checking bench for the sdram pin stage
`timescale 1ns/1ns
`default_nettype none
module sdram_pin_interface_bench;
  import sdram_pin_pkg::*;
  logic sys_clk_i = 0, arst_n_i = 0, interface_disable_bit_i = 0, init_done_i = 0, took;
  logic cmd_valid_i = 0, sdram_access_i = 0, precharge_address_bit_i = 0, clock_gate_i = 1;
  logic shared_address_bit_ten_i = 0, row_strobe_out_o, column_strobe_out_o, write_strobe_out_o;
  logic memory_clock_gate_out_o, byte_mask_out_o, memory_clock_out_o, cmd_oe_o, mask_oe_o;
  logic clock_oe_o, address_ten_o, address_ten_oe_o;
  logic [2:0] cmd_i = CMD_NOP, s, x;
  int failures = 0, check_count = 0;
  assign s = {row_strobe_out_o, column_strobe_out_o, write_strobe_out_o};
  sdram_pin_interface dut (.*);
  sdram_chip_model mem (.clk_i(memory_clock_out_o), .mask_i(byte_mask_out_o), .cmd_i(s),
    .took_o(took));
  initial forever #2 sys_clk_i = ~sys_clk_i;
  task automatic st(input int n); repeat (n) @(posedge sys_clk_i); #1; endtask
  task automatic chk(input logic [2:0] e, g);
    check_count++;
    if (g !== e) begin failures++; $display("FAIL %0t got %h want %h", $time, g, e); end
  endtask
  task automatic test_done;
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_init;
    st(2); chk(3'h0, {cmd_oe_o, mask_oe_o, clock_oe_o}); chk(3'h0, {2'h0, address_ten_oe_o});
    st(6); arst_n_i = 1; st(2); chk(3'h7, {cmd_oe_o, mask_oe_o, clock_oe_o}); chk(CMD_NOP, s);
    chk(3'h1, {2'h0, address_ten_oe_o});
    cmd_i = CMD_WRITE; cmd_valid_i = 1; st(4); chk(3'h0, {2'h0, took});
    init_done_i = 1; st(4); chk(3'h1, {2'h0, took}); chk(3'h0, {2'h0, byte_mask_out_o});
  endtask
  task automatic t_cmd;
    for (int i = 0; i < 8; i++) begin cmd_i = 3'(i); st(1); chk(3'(i), s); end
    cmd_i = CMD_REF; clock_gate_i = 0;
    for (int k = 0; k < 4; k++) begin
      {sdram_access_i, precharge_address_bit_i} = 2'(k); shared_address_bit_ten_i = !k[0];
      st(1); chk({2'h0, k[1] ? k[0] : !k[0]}, {2'h0, address_ten_o});
    end
    chk(CMD_REF, s); chk(3'h0, {2'h0, memory_clock_gate_out_o});
  endtask
  task automatic t_off;
    interface_disable_bit_i = 1; cmd_i = CMD_ACT; st(3);
    x = {memory_clock_out_o, memory_clock_gate_out_o, 1'b0}; clock_gate_i = 1; st(3);
    chk(x, {memory_clock_out_o, memory_clock_gate_out_o, 1'b0}); chk(CMD_NOP, s);
  endtask
  initial begin t_init; t_cmd; t_off; test_done; end
  initial begin #4000; failures++; test_done; end
endmodule
`default_nettype wire
